// file: src/tpg_pkg.sv
package tpg_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam logic [4:0] CTRL_RST = 5'h00;

	// ****************************************
	// Scheme select codes
	// ****************************************
	localparam logic [2:0] SCH_SIX    = 3'h0;
	localparam logic [2:0] SCH_THREE  = 3'h1;
	localparam logic [2:0] SCH_SINGLE = 3'h2;
	localparam logic [2:0] SCH_HB     = 3'h3;
	localparam logic [2:0] SCH_C_FET  = 3'h4;
	localparam logic [2:0] SCH_A_FET  = 3'h5;
	localparam logic [2:0] SCH_BC_FET = 3'h6;
	localparam logic [2:0] SCH_FET    = 3'h7;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int DEAD_TIME_NS  = 100;
	localparam int DEAD_CYC      = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic       coast;
		logic       rect_async;
		logic [2:0] scheme;
	} tpg_ctrl_s;

	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
	} tpg_gate_s;

endpackage

// file: src/tpg_decoder.sv
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Serial variant offers eight schemes, strap variant seven; strap refuses code 100b.
// - Codes 000b,001b,010b,011b select six-input, three-input, single-input, half-bridge drive.
// - 100b: A,B half-bridge, C FET; 101b: A FET; 110b: A half-bridge, B,C FET.
// - Code 111b drives every gate independently on all phases.
// - Six-input: high-only turns high gate, low-only turns low gate, else both off.
// - Three-input: low-side input low gives off; otherwise high input picks the gate.
// - Single-input: phase A high-side input is the pulse source.
// - Single-input: A low, B high, B low inputs form the commutation state.
// - Direction-low state codes pick source and sink phases; sink low gate stays on.
// - Code 000 turns all off; 111 aligns A pulsing, B and C lows on.
// - Direction input high uses the complemented state code, except stop 000 and align 111.
// - Brake input low turns all highs off, and all lows on unless coast is selected.
// - Synchronous rectification by default; serial variant bit selects freewheeling.
// - Serial variant bit selects brake or coast in single-input drive.
// - Half-bridge phases get automatic dead time; both gates never on together.
// - Half-bridge drive: low-side input low gives off; else high input picks gate.
// - Independent FET drive: gates follow inputs, no dead time, both may be on.
// - Mixed schemes: FET phases bypass dead time, half-bridge phases keep it.
// - Freewheeling keeps the switching low gate off, everything else unchanged.
module tpg_decoder #(
	parameter bit         SERIAL_VARIANT = 1'b1,
	parameter logic [7:0] DEAD_CYC       = 8'(tpg_pkg::DEAD_CYC)
) (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic [2:0]  phase_high_side_in,
	input  wire logic [2:0]  phase_low_side_in,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic      [2:0]  phase_high_gate_cmd,
	output logic      [2:0]  phase_low_gate_cmd
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	tpg_pkg::tpg_gate_s in_meta_q;
	tpg_pkg::tpg_gate_s in_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			in_meta_q <= '0;
			in_q      <= '0;
		end else begin
			in_meta_q <= {phase_high_side_in, phase_low_side_in};
			in_q      <= in_meta_q;
		end
	end

	// ****************************************
	// Control register
	// ****************************************
	tpg_pkg::tpg_ctrl_s ctrl_q;
	tpg_pkg::tpg_ctrl_s ctrl_w;
	logic               brake_act;

	assign ctrl_w = reg_wdata[4:0];

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= tpg_pkg::CTRL_RST;
		end else if (reg_wr && reg_addr == tpg_pkg::CTRL_OFS) begin
			// The strap variant has no pin setting for 100b, so such a write leaves the scheme as it was.
			if (SERIAL_VARIANT || ctrl_w.scheme != tpg_pkg::SCH_C_FET) begin
				ctrl_q.scheme <= ctrl_w.scheme;
			end
			ctrl_q.rect_async <= SERIAL_VARIANT & ctrl_w.rect_async;
			ctrl_q.coast      <= SERIAL_VARIANT & ctrl_w.coast;
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd && reg_addr == tpg_pkg::CTRL_OFS) begin
			reg_rdata <= {27'h0000000, ctrl_q};
		end else if (reg_rd && reg_addr == tpg_pkg::STAT_OFS) begin
			reg_rdata <= {25'h0000000, phase_high_gate_cmd, phase_low_gate_cmd, brake_act};
		end else begin
			reg_rdata <= '0;
		end
	end

	// ****************************************
	// Single-input commutation
	// ****************************************
	logic       pwm;
	logic       dir;
	logic       brake_n;
	logic [2:0] code_raw;
	logic [2:0] code;
	logic [2:0] src;
	logic [2:0] snk;
	logic [2:0] one_hi;
	logic [2:0] one_lo;

	assign pwm      = in_q.hi[0];
	assign dir      = in_q.hi[2];
	assign brake_n  = in_q.lo[2];
	assign code_raw = {in_q.lo[0], in_q.hi[1], in_q.lo[1]};
	assign brake_act = (ctrl_q.scheme == tpg_pkg::SCH_SINGLE) && !brake_n;

	always_comb begin
		// Stop and align read the same in both directions, so only steps are complemented.
		code = code_raw;
		if (dir && code_raw != 3'h0 && code_raw != 3'h7) begin
			code = ~code_raw;
		end
	end

	always_comb begin
		src = 3'h0;
		snk = 3'h0;
		case (code)
			3'h6: begin
				src = 3'h2;
				snk = 3'h4;
			end
			3'h4: begin
				src = 3'h1;
				snk = 3'h4;
			end
			3'h5: begin
				src = 3'h1;
				snk = 3'h2;
			end
			3'h1: begin
				src = 3'h4;
				snk = 3'h2;
			end
			3'h3: begin
				src = 3'h4;
				snk = 3'h1;
			end
			3'h2: begin
				src = 3'h2;
				snk = 3'h1;
			end
			3'h7: begin
				src = 3'h1;
				snk = 3'h6;
			end
			default: begin
				src = 3'h0;
				snk = 3'h0;
			end
		endcase
	end

	always_comb begin
		one_hi = src & {3{pwm}};
		// Freewheeling drops only the complementary low pulse on the source phase.
		one_lo = snk | (src & {3{!pwm && !ctrl_q.rect_async}});
		if (!brake_n) begin
			one_hi = 3'h0;
			one_lo = ctrl_q.coast ? 3'h0 : 3'h7;
		end
	end

	// ****************************************
	// Scheme decode
	// ****************************************
	logic [2:0] want_hi;
	logic [2:0] want_lo;
	logic [2:0] bypass;

	always_comb begin
		want_hi = in_q.hi & in_q.lo;
		want_lo = ~in_q.hi & in_q.lo;
		bypass  = 3'h0;
		case (ctrl_q.scheme)
			tpg_pkg::SCH_SIX: begin
				want_hi = in_q.hi & ~in_q.lo;
				want_lo = in_q.lo & ~in_q.hi;
			end
			tpg_pkg::SCH_THREE, tpg_pkg::SCH_HB: begin
			end
			tpg_pkg::SCH_SINGLE: begin
				want_hi = one_hi;
				want_lo = one_lo;
			end
			tpg_pkg::SCH_C_FET: bypass = 3'h4;
			tpg_pkg::SCH_A_FET: bypass = 3'h1;
			tpg_pkg::SCH_BC_FET: bypass = 3'h6;
			default: bypass = 3'h7;
		endcase
		want_hi = (want_hi & ~bypass) | (in_q.hi & bypass);
		want_lo = (want_lo & ~bypass) | (in_q.lo & bypass);
	end

	// ****************************************
	// Dead time and gate registers
	// ****************************************
	logic [7:0] cnt_q [3];

	for (genvar i = 0; i < 3; i++) begin : g_phase
		logic cnt_zero;
		logic hi_d;
		logic lo_d;

		assign cnt_zero = cnt_q[i] == 8'h00;

		always_comb begin
			hi_d = want_hi[i];
			lo_d = want_lo[i];
			if (!bypass[i]) begin
				// A gate may only turn on once the other is off and the gap has run out.
				hi_d = want_hi[i] && !phase_low_gate_cmd[i] && (phase_high_gate_cmd[i] || cnt_zero);
				lo_d = want_lo[i] && !want_hi[i] && !phase_high_gate_cmd[i] && (phase_low_gate_cmd[i] || cnt_zero);
			end
		end

		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				phase_high_gate_cmd[i] <= 1'b0;
				phase_low_gate_cmd[i]  <= 1'b0;
			end else begin
				phase_high_gate_cmd[i] <= hi_d;
				phase_low_gate_cmd[i]  <= lo_d;
			end
		end

		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				cnt_q[i] <= 8'h00;
			end else if (!bypass[i] && ((phase_high_gate_cmd[i] && !hi_d) || (phase_low_gate_cmd[i] && !lo_d))) begin
				cnt_q[i] <= DEAD_CYC;
			end else if (bypass[i]) begin
				cnt_q[i] <= 8'h00;
			end else if (!cnt_zero) begin
				cnt_q[i] <= cnt_q[i] - 8'h01;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// Idle time of each phase A gate, counted apart from the dead-time counter so a short gap would show.
	logic [7:0] lo_gap_q;
	logic [7:0] hi_gap_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			lo_gap_q <= 8'hFF;
		end else if (phase_low_gate_cmd[0]) begin
			lo_gap_q <= 8'h00;
		end else if (lo_gap_q != 8'hFF) begin
			lo_gap_q <= lo_gap_q + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hi_gap_q <= 8'hFF;
		end else if (phase_high_gate_cmd[0]) begin
			hi_gap_q <= 8'h00;
		end else if (hi_gap_q != 8'hFF) begin
			hi_gap_q <= hi_gap_q + 8'h01;
		end
	end

	sequence s_high_turn_on;
		$rose(phase_high_gate_cmd[0]) && !$past(bypass[0]);
	endsequence

	sequence s_low_turn_on;
		$rose(phase_low_gate_cmd[0]) && !$past(bypass[0]);
	endsequence

	a_no_shoot_through: assert property (@(posedge ref_clk) disable iff (!rstn)
		((phase_high_gate_cmd & phase_low_gate_cmd & ~$past(bypass)) == 3'h0))
		else $error("half-bridge phase has both gates on");

	a_dead_gap_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
		s_high_turn_on |-> lo_gap_q > DEAD_CYC)
		else $error("high gate came on inside the dead time");

	a_low_gap_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
		s_low_turn_on |-> hi_gap_q > DEAD_CYC)
		else $error("low gate came on inside the dead time");

	a_reset_all_off: assert property (@(posedge ref_clk)
		$rose(rstn) |-> (phase_high_gate_cmd == 3'h0 && phase_low_gate_cmd == 3'h0))
		else $error("gates not off after reset");

	a_six_both_off: assert property (@(posedge ref_clk) disable iff (!rstn)
		(ctrl_q.scheme == tpg_pkg::SCH_SIX && in_q.hi[0] == in_q.lo[0])
		|=> !phase_high_gate_cmd[0] && !phase_low_gate_cmd[0])
		else $error("six-input equal pair did not turn phase off");

	a_three_hiz: assert property (@(posedge ref_clk) disable iff (!rstn)
		(ctrl_q.scheme == tpg_pkg::SCH_THREE && !in_q.lo[1])
		|=> !phase_high_gate_cmd[1] && !phase_low_gate_cmd[1])
		else $error("three-input low-side low did not turn phase off");

	a_fet_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
		(ctrl_q.scheme == tpg_pkg::SCH_FET) [*4]
		|-> phase_high_gate_cmd == $past(phase_high_side_in, 3) && phase_low_gate_cmd == $past(phase_low_side_in, 3))
		else $error("independent gates did not follow inputs after three cycles");

	a_brake_highs_off: assert property (@(posedge ref_clk) disable iff (!rstn)
		brake_act |=> phase_high_gate_cmd == 3'h0)
		else $error("brake left a high gate on");

	a_coast_all_off: assert property (@(posedge ref_clk) disable iff (!rstn)
		(brake_act && ctrl_q.coast) |=> phase_low_gate_cmd == 3'h0 && phase_high_gate_cmd == 3'h0)
		else $error("coast left a gate on");

	a_stop_all_off: assert property (@(posedge ref_clk) disable iff (!rstn)
		(ctrl_q.scheme == tpg_pkg::SCH_SINGLE && brake_n && code_raw == 3'h0)
		|=> phase_low_gate_cmd == 3'h0 && phase_high_gate_cmd == 3'h0)
		else $error("stop code left a gate on");

	a_strap_no_100: assert property (@(posedge ref_clk) disable iff (!rstn)
		!SERIAL_VARIANT |-> ctrl_q.scheme != tpg_pkg::SCH_C_FET)
		else $error("strap variant holds scheme 100b");

	a_async_low_off: assert property (@(posedge ref_clk) disable iff (!rstn)
		(ctrl_q.scheme == tpg_pkg::SCH_SINGLE && ctrl_q.rect_async && brake_n && code_raw == 3'h7)
		|=> !phase_low_gate_cmd[0])
		else $error("freewheeling drove the source low gate");

	a_hb_phase_off: assert property (@(posedge ref_clk) disable iff (!rstn)
		(ctrl_q.scheme == tpg_pkg::SCH_HB && !in_q.lo[2])
		|=> !phase_high_gate_cmd[2] && !phase_low_gate_cmd[2])
		else $error("half-bridge low-side low did not turn phase off");

	a_mixed_fet_both: assert property (@(posedge ref_clk) disable iff (!rstn)
		(ctrl_q.scheme == tpg_pkg::SCH_C_FET && in_q.hi[2] && in_q.lo[2])
		|=> phase_high_gate_cmd[2] && phase_low_gate_cmd[2])
		else $error("independent phase did not turn both gates on");

	a_step_idle_off: assert property (@(posedge ref_clk) disable iff (!rstn)
		(ctrl_q.scheme == tpg_pkg::SCH_SINGLE && brake_n
		&& ((!dir && code_raw == 3'h6) || (dir && code_raw == 3'h1)))
		|=> !phase_high_gate_cmd[0] && !phase_low_gate_cmd[0] && !phase_high_gate_cmd[2])
		else $error("step from B to C left an idle gate on");

	a_align_highs_off: assert property (@(posedge ref_clk) disable iff (!rstn)
		(ctrl_q.scheme == tpg_pkg::SCH_SINGLE && brake_n && code_raw == 3'h7)
		|=> phase_high_gate_cmd[2:1] == 2'h0)
		else $error("align left a B or C high gate on");

endmodule // tpg_decoder

// file: test/tpg_ctrl_model.sv
`timescale 1ns/1ps
// ****************************************
// External controller model
// ****************************************
module tpg_ctrl_model (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       quiesce,
	input  wire logic [2:0] req_hi,
	input  wire logic [2:0] req_lo,
	output logic      [2:0] phase_high_side_in,
	output logic      [2:0] phase_low_side_in
);
	// Pins are launched from a flop on the same rising edge the decoder samples on, so they change just after that edge.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			phase_high_side_in <= 3'h0;
			phase_low_side_in  <= 3'h0;
		end else if (quiesce) begin
			phase_high_side_in <= 3'h0;
			phase_low_side_in  <= 3'h0;
		end else begin
			phase_high_side_in <= req_hi;
			phase_low_side_in  <= req_lo;
		end
	end
endmodule // tpg_ctrl_model

// file: test/tpg_decoder_tb_top.sv
`timescale 1ns/1ps
module tpg_decoder_tb_top;
	logic        ref_clk, rstn, reg_wr, reg_rd, quiesce, rd_q;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [2:0]  hi_in, lo_in, req_hi, req_lo, ghi, glo;
	int          err_count, compares, seed;
	logic [31:0] rq[$];
	logic [31:0] strap_rdata;
	logic [31:0] sq[$];
	logic [5:0]  gq[$];
	event        gate_ev;

	tpg_ctrl_model PRT (.ref_clk(ref_clk), .rstn(rstn), .quiesce(quiesce), .req_hi(req_hi), .req_lo(req_lo),
		.phase_high_side_in(hi_in), .phase_low_side_in(lo_in));
	tpg_decoder #(.DEAD_CYC(8'h02)) DUT (.ref_clk(ref_clk), .rstn(rstn), .phase_high_side_in(hi_in),
		.phase_low_side_in(lo_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_high_gate_cmd(ghi), .phase_low_gate_cmd(glo));
	tpg_decoder #(.SERIAL_VARIANT(1'b0), .DEAD_CYC(8'h02)) DUT_STRAP (.ref_clk(ref_clk), .rstn(rstn),
		.phase_high_side_in(hi_in), .phase_low_side_in(lo_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(strap_rdata), .phase_high_gate_cmd(),
		.phase_low_gate_cmd());

	// ****************************************
	// Reference decode
	// ****************************************
	function automatic tpg_pkg::tpg_gate_s expg(logic [2:0] s, h, l, logic ra, co);
		tpg_pkg::tpg_gate_s g;
		logic [2:0] c, fet;
		int src, snk;
		g = '0;
		fet = (s == 3'h7) ? 3'h7 : (s == 3'h4) ? 3'h4 : (s == 3'h5) ? 3'h1 : (s == 3'h6) ? 3'h6 : 3'h0;
		c = {l[0], h[1], l[1]};
		if (h[2] && c != 3'h0 && c != 3'h7) c = ~c;
		case (s)
			3'h0: begin g.hi = h & ~l; g.lo = l & ~h; end
			3'h2: begin
				if (!l[2]) g.lo = co ? 3'h0 : 3'h7;
				else if (c == 3'h7) begin g.hi[0] = h[0]; g.lo = {2'h3, ~h[0] & ~ra}; end
				else if (c != 3'h0) begin
					case (c)
						3'h6: begin src = 1; snk = 2; end
						3'h4: begin src = 0; snk = 2; end
						3'h5: begin src = 0; snk = 1; end
						3'h1: begin src = 2; snk = 1; end
						3'h3: begin src = 2; snk = 0; end
						default: begin src = 1; snk = 0; end
					endcase
					g.hi[src] = h[0];
					g.lo[src] = ~h[0] & ~ra;
					g.lo[snk] = 1'b1;
				end
			end
			default: begin g.hi = h & l; g.lo = ~h & l; end
		endcase
		g.hi = (g.hi & ~fet) | (h & fet);
		g.lo = (g.lo & ~fet) | (l & fet);
		return g;
	endfunction

	// ****************************************
	// Drivers and scoreboard
	// ****************************************
	task automatic reg_write(logic [3:0] a, logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(logic [3:0] a, logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a; reg_rd <= 1'b1;
		rq.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask

	task automatic gate_note(tpg_pkg::tpg_gate_s e);
		@(negedge ref_clk);
		gq.push_back(e);
		->gate_ev;
	endtask

	task automatic cmp_rd(logic [31:0] got, logic [31:0] e);
		compares++;
		if (got !== e) begin
			err_count++;
			$display("[ERR] %0t read data %h expected %h", $time, got, e);
		end
	endtask

	task automatic cmp_gate(logic [5:0] e);
		compares++;
		if ({ghi, glo} !== e) begin
			err_count++;
			$display("[ERR] %0t gates %b expected %b", $time, {ghi, glo}, e);
		end
	endtask

	always @(posedge ref_clk) rd_q <= reg_rd;
	always @(negedge ref_clk) begin
		if (rd_q === 1'b1 && rq.size() > 0) cmp_rd(reg_rdata, rq.pop_front());
		if (rd_q === 1'b1 && sq.size() > 0) cmp_rd(strap_rdata, sq.pop_front());
	end
	always @(gate_ev) cmp_gate(gq.pop_front());

	task automatic wrap_up;
		$display("counts: compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (100000) @(posedge ref_clk);
		err_count++;
		wrap_up();
	end

	initial begin
		logic [2:0] s, h, l;
		logic ra, co;
		tpg_pkg::tpg_gate_s e;
		seed = 57;
		rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0;
		quiesce = 1'b0; req_hi = 3'h7; req_lo = 3'h7;
		err_count = 0; compares = 0;
		repeat (5) @(posedge ref_clk);
		gate_note(6'h00);
		repeat (15) @(posedge ref_clk);
		rstn <= 1'b1;
		reg_read(4'h0, 32'h0);
		reg_read(4'h8, 32'h0);
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			s = k[2:0];
			ra = 1'($random(seed));
			co = 1'($random(seed));
			@(posedge ref_clk) quiesce <= 1'b1;
			repeat (14) @(posedge ref_clk);
			reg_write(4'h0, {27'h0, co, ra, s});
			sq.push_back({27'h0, 2'h0, (s == 3'h4) ? 3'h3 : s});
			reg_read(4'h0, {27'h0, co, ra, s});
			reg_write(4'h4, 32'h1F);
			@(posedge ref_clk) quiesce <= 1'b0;
			for (int n = 0; n < 24; n++) begin
				h = 3'($random(seed));
				l = 3'($random(seed));
				if (s == 3'h1 && n[0]) l = 3'h7;
				if (s == 3'h2 && n < 8) begin l[2] = 1'b1; h[2] = 1'b0; end
				@(posedge ref_clk);
				req_hi <= h; req_lo <= l;
				repeat ((s == 3'h7) ? 4 : 14) @(posedge ref_clk);
				e = expg(s, h, l, ra, co);
				gate_note(e);
				if (n == 23) reg_read(4'h4, {25'h0, e.hi, e.lo, (s == 3'h2) && !l[2]});
			end
			$display("test scheme %0d done", s);
		end
		repeat (4) @(posedge ref_clk);
		wrap_up();
	end
endmodule // tpg_decoder_tb_top
